// file: hw/ctsv_top.sv
`timescale 1ns/1ns
// What this block does
// [R1] The alarm path is qualified only while every current condition holds at once.
// [R2] Any phase magnitude above the high limit blocks qualification as a real fault.
// [R3] At least one phase magnitude must lie above the low limit.
// [R4] At least one phase magnitude must lie below the low limit.
// [R5] The smallest to largest phase magnitude ratio must fall below its threshold.
// [R6] The negative to positive sequence ratio must rise above its threshold.
// [R7] When enabled, the phase plus residual sum must exceed its threshold, else ignored.
// [R8] The alarm rises only after qualification has held for the whole alarm delay.
// [R9] Positive and negative sequence components are derived from the three phasors.
// [R10] Only fundamental frequency magnitudes feed the comparisons.
// [R11] The angle of each channel is followed through its phasor components.
// [R12] The residual source is none, residual channel one or residual channel two.
// [R13] With residual supervision off, residual quantities take no part.
// [R14] Each comparison releases at 97 or 103 percent of its setting; the squared sequence ratio and sum checks release near 98.5 percent.
// [R15] A polarity input adds or subtracts the residual in the sum.
// [R16] A compensate command while energized stores the present sum as offset.
// [R17] Any drop in qualification clears the timer and the alarm.
module ctsv_top
  import ctsv_pkg::*;
#(
  parameter int CYCLES_PER_MS = CYC_PER_MS
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Measurement strobe and fundamental magnitudes
  input wire logic meas_valid,
  input wire logic [MAG_W-1:0] mag_phase_current_a,
  input wire logic [MAG_W-1:0] mag_phase_current_b,
  input wire logic [MAG_W-1:0] mag_phase_current_c,
  // Fundamental phasors
  input wire logic signed [15:0] re_phase_current_a,
  input wire logic signed [15:0] im_phase_current_a,
  input wire logic signed [15:0] re_phase_current_b,
  input wire logic signed [15:0] im_phase_current_b,
  input wire logic signed [15:0] re_phase_current_c,
  input wire logic signed [15:0] im_phase_current_c,
  input wire logic signed [15:0] re_residual_channel_one,
  input wire logic signed [15:0] im_residual_channel_one,
  input wire logic signed [15:0] re_residual_channel_two,
  input wire logic signed [15:0] im_residual_channel_two,
  // Settings
  input wire logic [MAG_W-1:0] high_limit,
  input wire logic [MAG_W-1:0] low_limit,
  input wire logic [RATIO_W-1:0] minmax_ratio_threshold,
  input wire logic [RATIO_W-1:0] sequence_ratio_threshold,
  input wire logic [MAG_W-1:0] sum_difference_threshold,
  input wire logic sum_check_enable,
  input wire logic residual_enable,
  input wire logic [1:0] residual_select,
  input wire logic residual_subtract,
  input wire logic compensate_cmd,
  input wire logic [15:0] alarm_delay_time,
  // Status
  output logic conditions_met,
  output logic alarm
);
  typedef struct packed {
    ctsv_state_t st;
    logic [31:0] pre;
    logic [15:0] ms;
    logic signed [19:0] off_re;
    logic signed [19:0] off_im;
  } ctsv_top_t;

  ctsv_top_t s_q;
  ctsv_top_t s_d;
  ctsv_cmp_if #(.N(NCMP), .W(CMP_W)) cmp ();

  ctsv_hyst_bank #(.N(NCMP), .W(CMP_W)) u_bank (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cmp(cmp)
  );

  function automatic logic signed [19:0] sx(input logic signed [15:0] x);
    return 20'(x);
  endfunction

  // Sequence components, scaled by three
  logic signed [31:0] bre;
  logic signed [31:0] bim;
  logic signed [31:0] rot_re;
  logic signed [31:0] rot_im;
  logic signed [31:0] p_re;
  logic signed [31:0] p_im;
  logic signed [31:0] n_re;
  logic signed [31:0] n_im;
  logic [CMP_W-1:0] pos_sq;
  logic [CMP_W-1:0] neg_sq;

  always_comb
  begin
    // Phasors carry each channel angle into the rotation
    bre = (32'(re_phase_current_a) <<< SEQ_SHIFT)
      - (32'(32'(re_phase_current_b) + 32'(re_phase_current_c)) <<< (SEQ_SHIFT - 1)); // see [R11]
    bim = (32'(im_phase_current_a) <<< SEQ_SHIFT)
      - (32'(32'(im_phase_current_b) + 32'(im_phase_current_c)) <<< (SEQ_SHIFT - 1)); // see [R11]
    rot_re = SEQ_K * (32'(im_phase_current_b) - 32'(im_phase_current_c));
    rot_im = SEQ_K * (32'(re_phase_current_b) - 32'(re_phase_current_c));
    p_re = (bre - rot_re) >>> SEQ_SHIFT; // see [R9]
    p_im = (bim + rot_im) >>> SEQ_SHIFT; // see [R9]
    n_re = (bre + rot_re) >>> SEQ_SHIFT; // see [R9]
    n_im = (bim - rot_im) >>> SEQ_SHIFT; // see [R9]
    pos_sq = CMP_W'(p_re) * CMP_W'(p_re) + CMP_W'(p_im) * CMP_W'(p_im);
    neg_sq = CMP_W'(n_re) * CMP_W'(n_re) + CMP_W'(n_im) * CMP_W'(n_im);
  end

  // Residual selection and calculated sum
  logic signed [19:0] r_re;
  logic signed [19:0] r_im;
  logic signed [19:0] raw_re;
  logic signed [19:0] raw_im;
  logic signed [19:0] sum_re;
  logic signed [19:0] sum_im;

  always_comb
  begin
    r_re = '0;
    r_im = '0;
    if (residual_enable) // see [R13]
    begin
      case (ctsv_res_sel_t'(residual_select))
        RES_ONE:
        begin
          r_re = sx(re_residual_channel_one); // see [R12]
          r_im = sx(im_residual_channel_one);
        end
        RES_TWO:
        begin
          r_re = sx(re_residual_channel_two); // see [R12]
          r_im = sx(im_residual_channel_two);
        end
        default:
        begin
          r_re = '0;
          r_im = '0;
        end
      endcase
    end
    raw_re = sx(re_phase_current_a) + sx(re_phase_current_b) + sx(re_phase_current_c);
    raw_im = sx(im_phase_current_a) + sx(im_phase_current_b) + sx(im_phase_current_c);
    raw_re = residual_subtract ? raw_re - r_re : raw_re + r_re; // see [R15]
    raw_im = residual_subtract ? raw_im - r_im : raw_im + r_im; // see [R15]
    sum_re = raw_re - s_q.off_re;
    sum_im = raw_im - s_q.off_im;
  end

  // Comparator operands
  logic [MAG_W-1:0] mags [3];
  logic [MAG_W-1:0] mmin;
  logic [MAG_W-1:0] mmax;

  assign mags[0] = mag_phase_current_a;
  assign mags[1] = mag_phase_current_b;
  assign mags[2] = mag_phase_current_c;

  always_comb
  begin
    mmin = mags[0];
    mmax = mags[0];
    for (int i = 1; i < 3; i++)
    begin
      if (mags[i] < mmin)
        mmin = mags[i];
      if (mags[i] > mmax)
        mmax = mags[i];
    end
    cmp.upd = meas_valid;
    cmp.over = '0;
    for (int i = 0; i < 3; i++)
    begin
      cmp.val[IX_HIGH+i] = CMP_W'(mags[i]); // see [R10]
      cmp.thr[IX_HIGH+i] = CMP_W'(high_limit);
      cmp.over[IX_HIGH+i] = 1'b1;
      cmp.val[IX_LOW_ABOVE+i] = CMP_W'(mags[i]); // see [R10]
      cmp.thr[IX_LOW_ABOVE+i] = CMP_W'(low_limit);
      cmp.over[IX_LOW_ABOVE+i] = 1'b1;
      cmp.val[IX_LOW_BELOW+i] = CMP_W'(mags[i]); // see [R10]
      cmp.thr[IX_LOW_BELOW+i] = CMP_W'(low_limit);
    end
    // Ratios compared cross-multiplied, no divider needed
    cmp.val[IX_RATIO] = CMP_W'(mmin) * RATIO_FULL; // see [R5]
    cmp.thr[IX_RATIO] = CMP_W'(minmax_ratio_threshold) * CMP_W'(mmax);
    cmp.val[IX_SEQ] = neg_sq * RATIO_FULL_SQ; // see [R6]
    cmp.thr[IX_SEQ] = CMP_W'(sequence_ratio_threshold) * CMP_W'(sequence_ratio_threshold)
      * pos_sq;
    cmp.over[IX_SEQ] = 1'b1;
    cmp.val[IX_SUM] = CMP_W'(sum_re) * CMP_W'(sum_re) + CMP_W'(sum_im) * CMP_W'(sum_im); // see [R7]
    cmp.thr[IX_SUM] = CMP_W'(sum_difference_threshold) * CMP_W'(sum_difference_threshold);
    cmp.over[IX_SUM] = 1'b1;
  end

  // Qualification
  logic high_ok;
  logic any_above;
  logic any_below;
  logic sum_ok;
  logic qual;
  logic energized;

  always_comb
  begin
    high_ok = ~|cmp.flag[IX_HIGH +: 3]; // see [R2]
    any_above = |cmp.flag[IX_LOW_ABOVE +: 3]; // see [R3]
    any_below = |cmp.flag[IX_LOW_BELOW +: 3]; // see [R4]
    sum_ok = !sum_check_enable || cmp.flag[IX_SUM]; // see [R7]
    qual = high_ok && any_above && any_below && cmp.flag[IX_RATIO]
      && cmp.flag[IX_SEQ] && sum_ok; // see [R1]
    energized = any_above;
  end

  // Definite delay timer
  always_comb
  begin
    s_d = s_q;
    if (compensate_cmd && energized)
    begin
      s_d.off_re = raw_re; // see [R16]
      s_d.off_im = raw_im; // see [R16]
    end
    if (!qual)
      {s_d.pre, s_d.ms} = '0; // see [R17]
    case (s_q.st)
      ST_IDLE:
      begin
        s_d.pre = '0;
        s_d.ms = '0;
        if (qual)
          s_d.st = ST_TIMING;
      end
      ST_TIMING:
      begin
        if (!qual)
          s_d.st = ST_IDLE; // see [R17]
        else if (s_q.ms >= alarm_delay_time)
          s_d.st = ST_ALARM; // see [R8]
        else if (s_q.pre == 32'(CYCLES_PER_MS - 1))
        begin
          s_d.pre = '0;
          s_d.ms = s_q.ms + 16'h0001;
        end
        else
          s_d.pre = s_q.pre + 32'h0000_0001;
      end
      ST_ALARM:
      begin
        if (!qual)
          s_d.st = ST_IDLE; // see [R17]
      end
      default:
        s_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q.st <= ST_IDLE;
      s_q.pre <= '0;
      s_q.ms <= '0;
      s_q.off_re <= OFFSET_RST;
      s_q.off_im <= OFFSET_RST;
    end
    else
      s_q <= s_d;
  end

  assign alarm = (s_q.st == ST_ALARM);
  assign conditions_met = qual;

  sequence s_drop;
    !qual;
  endsequence

  property p_alarm_qual;
    @(posedge ref_clk) disable iff (!rst_n) !conditions_met |=> !alarm;
  endproperty
  a_alarm_qual: assert property (p_alarm_qual) // see [R1]
    else $error("Alarm without all conditions");

  property p_high_blocks;
    @(posedge ref_clk) disable iff (!rst_n) (|cmp.flag[IX_HIGH +: 3]) |=> !alarm;
  endproperty
  a_high_blocks: assert property (p_high_blocks) // see [R2]
    else $error("Alarm with a phase above high limit");

  property p_above;
    @(posedge ref_clk) disable iff (!rst_n) !any_above |=> !alarm;
  endproperty
  a_above: assert property (p_above) // see [R3]
    else $error("Alarm with no phase above low limit");

  property p_below;
    @(posedge ref_clk) disable iff (!rst_n) !any_below |=> !alarm;
  endproperty
  a_below: assert property (p_below) // see [R4]
    else $error("Alarm with no phase below low limit");

  property p_ratio_seq;
    @(posedge ref_clk) disable iff (!rst_n) !(cmp.flag[IX_RATIO] && cmp.flag[IX_SEQ]) |=> !alarm;
  endproperty
  a_ratio_seq: assert property (p_ratio_seq) // see [R5]
    else $error("Alarm without ratio conditions");

  property p_sum;
    @(posedge ref_clk) disable iff (!rst_n)
    sum_check_enable && !cmp.flag[IX_SUM] |=> !alarm;
  endproperty
  a_sum: assert property (p_sum) // see [R7]
    else $error("Alarm without sum difference");

  property p_delay;
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(alarm) |-> $past(s_q.ms) >= $past(alarm_delay_time) && $past(s_q.st) == ST_TIMING;
  endproperty
  a_delay: assert property (p_delay) // see [R8]
    else $error("Alarm before delay elapsed");

  property p_drop;
    @(posedge ref_clk) disable iff (!rst_n) s_drop |=> !alarm && s_q.ms == 16'h0000 ##1 1'b1;
  endproperty
  a_drop: assert property (p_drop) // see [R17]
    else $error("Timer or alarm kept after drop");

  property p_comp;
    @(posedge ref_clk) disable iff (!rst_n)
    compensate_cmd && energized |=> s_q.off_re == $past(raw_re) && s_q.off_im == $past(raw_im);
  endproperty
  a_comp: assert property (p_comp) // see [R16]
    else $error("Offset not captured");
endmodule

// file: hw/ctsv_pkg.sv
package ctsv_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int DELAY_UNIT_MS = 1;
  localparam int CYC_PER_MS = CLK_HZ / 1000 * DELAY_UNIT_MS;
  localparam int MAG_W = 16;
  localparam int RATIO_W = 14;
  localparam int CMP_W = 72;
  localparam int NCMP = 12;
  // Hysteresis in percent of the threshold
  localparam int HYS_BASE_PCT = 100;
  localparam int HYS_LO_PCT = 97;
  localparam int HYS_HI_PCT = 103;
  // Ratio settings are in 0.01 % steps
  localparam logic [CMP_W-1:0] RATIO_FULL = 72'h00_0000_0000_0000_2710;
  localparam logic [CMP_W-1:0] RATIO_FULL_SQ = 72'h00_0000_0000_05F5_E100;
  // 0.866 scaled by 2^10 for the sequence rotation
  localparam logic signed [31:0] SEQ_K = 32'h0000_0377;
  localparam int SEQ_SHIFT = 10;
  // Comparator slots
  localparam int IX_HIGH = 0;
  localparam int IX_LOW_ABOVE = 3;
  localparam int IX_LOW_BELOW = 6;
  localparam int IX_RATIO = 9;
  localparam int IX_SEQ = 10;
  localparam int IX_SUM = 11;
  localparam logic signed [19:0] OFFSET_RST = 20'h0_0000;
  typedef enum logic [1:0] {
    RES_NONE = 2'h0,
    RES_ONE = 2'h1,
    RES_TWO = 2'h2
  } ctsv_res_sel_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_TIMING = 2'h1,
    ST_ALARM = 2'h3
  } ctsv_state_t;
endpackage

// file: hw/ctsv_cmp_if.sv
`timescale 1ns/1ns
interface ctsv_cmp_if #(
  parameter int N = 12,
  parameter int W = 72
);
  logic [N-1:0][W-1:0] val;
  logic [N-1:0][W-1:0] thr;
  logic [N-1:0] over;
  logic [N-1:0] flag;
  logic upd;
  modport src (output val, output thr, output over, output upd, input flag);
  modport bank (input val, input thr, input over, input upd, output flag);
endinterface

// file: hw/ctsv_hyst_bank.sv
`timescale 1ns/1ns
module ctsv_hyst_bank
  import ctsv_pkg::*;
#(
  parameter int N = NCMP,
  parameter int W = CMP_W
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Comparator slots
  ctsv_cmp_if.bank cmp
);
  typedef struct packed {
    logic [N-1:0] flag;
  } ctsv_bank_t;

  ctsv_bank_t s_q;
  ctsv_bank_t s_d;
  logic [N-1:0][W+6:0] v100;
  logic [N-1:0][W+6:0] t100;
  logic [N-1:0][W+6:0] t97;
  logic [N-1:0][W+6:0] t103;

  for (genvar i = 0; i < N; i++)
  begin : g_cmp
    assign v100[i] = (W+7)'(cmp.val[i]) * (W+7)'(HYS_BASE_PCT);
    assign t100[i] = (W+7)'(cmp.thr[i]) * (W+7)'(HYS_BASE_PCT);
    assign t97[i] = (W+7)'(cmp.thr[i]) * (W+7)'(HYS_LO_PCT);
    assign t103[i] = (W+7)'(cmp.thr[i]) * (W+7)'(HYS_HI_PCT);
  end

  always_comb
  begin
    s_d = s_q;
    if (cmp.upd)
    begin
      for (int i = 0; i < N; i++)
      begin
        // Picks up at the setting, releases at 97 % or 103 % of it
        if (cmp.over[i])
        begin
          if (v100[i] > t100[i])
            s_d.flag[i] = 1'b1; // see [R14]
          else if (v100[i] < t97[i])
            s_d.flag[i] = 1'b0; // see [R14]
        end
        else
        begin
          if (v100[i] < t100[i])
            s_d.flag[i] = 1'b1; // see [R14]
          else if (v100[i] > t103[i])
            s_d.flag[i] = 1'b0; // see [R14]
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign cmp.flag = s_q.flag;

  property p_hys_hold;
    @(posedge ref_clk) disable iff (!rst_n)
    cmp.upd && cmp.over[0] && s_q.flag[0] && (v100[0] >= t97[0]) |=> s_q.flag[0];
  endproperty
  a_hys_hold: assert property (p_hys_hold) // see [R14]
    else $error("Over flag released above 97 percent point");
endmodule

// file: bench/ctsv_meas_model.sv
`timescale 1ns/1ns
module ctsv_meas_model
  import ctsv_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Requested phase magnitudes
  input wire logic [MAG_W-1:0] set_a,
  input wire logic [MAG_W-1:0] set_b,
  input wire logic [MAG_W-1:0] set_c,
  // Measurement chain outputs
  output logic meas_valid,
  output logic [MAG_W-1:0] mag_a,
  output logic [MAG_W-1:0] mag_b,
  output logic [MAG_W-1:0] mag_c,
  output logic signed [15:0] re_a,
  output logic signed [15:0] im_a,
  output logic signed [15:0] re_b,
  output logic signed [15:0] im_b,
  output logic signed [15:0] re_c,
  output logic signed [15:0] im_c
);
  // Fundamental phasors at 0, -120 and +120 degrees; all fields move together
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meas_valid <= 1'b0;
      {mag_a, mag_b, mag_c} <= '0;
      {re_a, im_a, re_b, im_b, re_c, im_c} <= '0;
    end
    else
    begin
      meas_valid <= 1'b1;
      mag_a <= set_a;
      mag_b <= set_b;
      mag_c <= set_c;
      re_a <= 16'(int'(set_a));
      im_a <= 16'h0000;
      re_b <= 16'(-(int'(set_b) / 2));
      im_b <= 16'(-(int'(set_b) * 866 / 1000));
      re_c <= 16'(-(int'(set_c) / 2));
      im_c <= 16'(int'(set_c) * 866 / 1000);
    end
  end
endmodule

// file: bench/tb.sv
`timescale 1ns/1ns
module tb;
  import ctsv_pkg::*;
  localparam int NPM = 4;
  localparam int DLY = 2 * NPM;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] pa = '0, pb = '0, pc = '0;
  logic mv;
  logic [15:0] ma, mb, mc;
  logic signed [15:0] ra, ia, rb, ib, rc, ic;
  // Channel one doubles the phase sum when added, channel two cancels it
  logic signed [15:0] r1 = 16'h00FA, i1 = 16'hFE4F, r2 = 16'hFF06, i2 = 16'h01B1;
  logic [15:0] sum_thr = 16'h0032;
  logic sum_en = 1'b0, res_en = 1'b0, res_sub = 1'b0, comp = 1'b0;
  logic [1:0] res_sel = 2'h0;
  logic conditions_met, alarm;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;

  initial forever #5 ref_clk = ~ref_clk;

  ctsv_meas_model i_ctsv_meas_model (.ref_clk(ref_clk), .rst_n(rst_n), .set_a(pa),
    .set_b(pb), .set_c(pc), .meas_valid(mv), .mag_a(ma), .mag_b(mb), .mag_c(mc),
    .re_a(ra), .im_a(ia), .re_b(rb), .im_b(ib), .re_c(rc), .im_c(ic));

  ctsv_top #(.CYCLES_PER_MS(NPM)) i_ctsv_top (.ref_clk(ref_clk), .rst_n(rst_n),
    .meas_valid(mv), .mag_phase_current_a(ma), .mag_phase_current_b(mb),
    .mag_phase_current_c(mc), .re_phase_current_a(ra), .im_phase_current_a(ia),
    .re_phase_current_b(rb), .im_phase_current_b(ib), .re_phase_current_c(rc),
    .im_phase_current_c(ic), .re_residual_channel_one(r1), .im_residual_channel_one(i1),
    .re_residual_channel_two(r2), .im_residual_channel_two(i2), .high_limit(16'h03E8),
    .low_limit(16'h0064), .minmax_ratio_threshold(14'h03E8),
    .sequence_ratio_threshold(14'h1324), .sum_difference_threshold(sum_thr),
    .sum_check_enable(sum_en), .residual_enable(res_en), .residual_select(res_sel),
    .residual_subtract(res_sub), .compensate_cmd(comp), .alarm_delay_time(16'h0002),
    .conditions_met(conditions_met), .alarm(alarm));

  task automatic summarize();
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard well beyond the longest scenario
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      mismatches++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Model stage plus flag stage, with margin
  task automatic apply(input int a, input int b, input int c);
    @(posedge ref_clk);
    #1;
    pa = 16'(a);
    pb = 16'(b);
    pc = 16'(c);
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  // Cycles from qualification to alarm
  task automatic time_alarm();
    n = 0;
    while (conditions_met !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    n = 0;
    while (alarm !== 1'b1 && n < 60)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask

  task automatic t_balanced();
    apply(500, 500, 500);
    check(conditions_met, 1'b0);
    check(alarm, 1'b0);
  endtask

  task automatic t_delay();
    @(posedge ref_clk);
    #1;
    pc = 16'h0000;
    time_alarm();
    check(n >= DLY + 1 && n <= DLY + 3, 1'b1);
    apply(500, 500, 500);
    check(alarm, 1'b0);
  endtask

  task automatic t_restart();
    apply(500, 500, 0);
    repeat (3) @(posedge ref_clk);
    apply(500, 500, 500);
    check(alarm, 1'b0);
    @(posedge ref_clk);
    #1;
    pc = 16'h0000;
    time_alarm();
    check(n >= DLY + 1 && n <= DLY + 3, 1'b1);
  endtask

  task automatic t_high();
    apply(1010, 1010, 0);
    check(conditions_met, 1'b0);
    apply(990, 990, 0);
    check(conditions_met, 1'b0);
    apply(960, 960, 0);
    check(conditions_met, 1'b1);
    apply(990, 990, 0);
    check(conditions_met, 1'b1);
  endtask

  // Residual modes: {enable, select, subtract, expected}
  task automatic t_sum();
    logic [4:0] tbl [7];
    tbl = '{5'b1_01_0_1, 5'b1_01_1_0, 5'b1_00_0_1, 5'b1_10_0_0, 5'b1_11_0_1,
      5'b0_01_0_1, 5'b1_10_1_1};
    sum_en = 1'b1;
    foreach (tbl[k])
    begin
      @(posedge ref_clk);
      #1;
      {res_en, res_sel, res_sub} = tbl[k][4:1];
      apply(500, 500, 0);
      check(conditions_met, tbl[k][0]);
    end
    res_en = 1'b0;
    sum_thr = 16'h0258;
    apply(500, 500, 0);
    check(conditions_met, 1'b0);
    sum_en = 1'b0;
    apply(500, 500, 0);
    check(conditions_met, 1'b1);
  endtask

  task automatic t_comp();
    sum_en = 1'b1;
    sum_thr = 16'h0032;
    apply(500, 500, 0);
    check(conditions_met, 1'b1);
    comp = 1'b1;
    @(posedge ref_clk);
    #1;
    comp = 1'b0;
    apply(500, 500, 0);
    check(conditions_met, 1'b0);
    apply(500, 600, 0);
    check(conditions_met, 1'b1);
  endtask

  initial
  begin
    repeat (2) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    check(alarm, 1'b0);
    t_balanced();
    t_delay();
    t_restart();
    t_high();
    t_sum();
    t_comp();
    summarize();
  end
endmodule
